// ===== pkg/rtc_alarm_consts.vh
// constants for the alarm and backup-gating block
`ifndef RTC_ALARM_CONSTS_VH
`define RTC_ALARM_CONSTS_VH
// ******************************************************
// register offsets (register index on the bus)
// ******************************************************
`define RA_SEC_MATCH 4'h0
`define RA_MIN_MATCH 4'h1
`define RA_HOUR_MATCH 4'h2
`define RA_DATE_MATCH 4'h3
`define RA_MONTH_MATCH 4'h4
`define RA_WDAY_MATCH 4'h5
`define RA_INT_CTRL 4'h6
`define RA_STATUS 4'h7
`define RA_PWR_CTRL 4'h8
// ******************************************************
// field positions
// ******************************************************
`define MATCH_EN_BIT 7
`define INT_ALARM_ZERO_ENABLE_BIT 5
`define INT_IM_BIT 7
`define STAT_AL0_BIT 0
`define PWR_BSW_BIT 0
`define PWR_SERIAL_BUS_IN_BACKUP_BIT 1
// ******************************************************
// reset values
// ******************************************************
`define MATCH_RST 8'h00
`define INT_RST 8'h00
`define PWR_BSW_RST 1'b1
`define PWR_SERIAL_BUS_IN_BACKUP_RST 1'b0
// ******************************************************
// timing
// ******************************************************
`define IRQ_PULSE_NS 1000
`define CLK_NS 10
// pulse length in mclk cycles, sized for the 7-bit pulse counter
// (IRQ_PULSE_NS rounded up to whole CLK_NS periods)
`define IRQ_PULSE_CYC 7'h64
`endif

// ===== verilog/sync2.v
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	input wire d,
	output wire q
);
	reg s1_r; // first stage, read only by s2_r
	reg s2_r; // second stage, safe to use
	// ******************************************************
	// two stages
	// ******************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else if (ce) begin
			s1_r <= d;
			s2_r <= s1_r;
		end
	end
	assign q = s2_r;
endmodule

// ===== verilog/field_match.v
// one alarm field compare: enable bit plus bcd target
`timescale 1ns/1ps
`include "rtc_alarm_consts.vh"
module field_match (
	input wire [7:0] match_reg,
	input wire [6:0] cur_value,
	output wire hit
);
	// ******************************************************
	// compare
	// ******************************************************
	// a disabled field (incl. all-zero register) always agrees
	assign hit = ~match_reg[`MATCH_EN_BIT] |
		(match_reg[6:0] == cur_value);
endmodule

// ===== verilog/rtc_alarm_gate.v
// alarm 0 matching and backup-mode bus gating of a serial rtc
// Operation
// - bus off whenever supply below reset threshold
// - mode 00: trip switchover, bus above reset, irq pin off in backup
// - mode 01: vdd<vbat switchover, bus above reset, in backup also needs vbat above reset
// - mode 10: like 00, irq pin kept active
// - mode 11: bus only above max(reset,vbat)
// - six fields; all-zero register is ignored
// - bit 7 enables field, rest is bcd
// - hour field holds bcd hour below enable
// - alarm fires only with enable bit 5
// - repeat select 0 gives single event
// - flag set when seconds roll to match
// - repeat select 1 pulses on each match
// - repeat select is interrupt control bit 7
// - repeat mode sets flag every trigger
// - power-up defaults to legacy switchover
`timescale 1ns/1ps
`include "rtc_alarm_consts.vh"
module rtc_alarm_gate (
	input wire mclk,
	input wire rst_n,
	input wire ce,
	// register port of the device (from the bus front end)
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// 1 hz time base, from the oscillator domain
	input wire tick_1hz,
	// current time, bcd, already updated on each tick
	input wire [6:0] cur_sec,
	input wire [6:0] cur_min,
	input wire [5:0] cur_hour,
	input wire [5:0] cur_date,
	input wire [4:0] cur_month,
	input wire [2:0] cur_wday,
	// supervisor comparator flags (asynchronous)
	input wire vdd_above_reset,
	input wire vdd_above_trip,
	input wire vdd_above_vbat,
	input wire vbat_above_reset,
	// outputs
	output wire bus_enable,
	output wire in_backup,
	output wire frequency_or_interrupt_pin_active,
	output wire alarm_irq,
	output wire alarm_zero_flag
);
	// ******************************************************
	// input synchronisers
	// ******************************************************
	wire tick_s; // synchronised 1 hz level
	wire vdd_rst_s; // vdd above reset threshold
	wire vdd_trip_s; // vdd above trip threshold
	wire vdd_vbat_s; // vdd above backup supply
	wire vbat_rst_s; // backup supply above reset threshold
	sync2 u_sync_tick (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.d(tick_1hz), .q(tick_s));
	sync2 u_sync_vr (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.d(vdd_above_reset), .q(vdd_rst_s));
	sync2 u_sync_vt (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.d(vdd_above_trip), .q(vdd_trip_s));
	sync2 u_sync_vb (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.d(vdd_above_vbat), .q(vdd_vbat_s));
	sync2 u_sync_br (.mclk(mclk), .rst_n(rst_n), .ce(ce),
		.d(vbat_above_reset), .q(vbat_rst_s));

	// ******************************************************
	// registers
	// ******************************************************
	reg [7:0] sec_match_r; // alarm0_second_match
	reg [7:0] min_match_r; // alarm0_minute_match
	reg [7:0] hour_match_r; // alarm0_hour_match
	reg [7:0] date_match_r; // alarm0_date_match
	reg [7:0] month_match_r; // alarm0_month_match
	reg [7:0] wday_match_r; // alarm0_weekday_match
	reg [7:0] int_ctrl_r; // interrupt_control
	reg al0_flag_r; // alarm_zero_flag
	reg bsw_r; // backup_switch_select
	reg serial_bus_in_backup_r; // serial_bus_in_backup
	reg single_done_r; // single event already fired
	reg tick_d_r; // previous tick level
	reg tick_seen_r; // tick edge delayed one cycle
	reg [6:0] pulse_cnt_r; // irq pulse length counter
	reg [6:0] pulse_cnt_nxt;

	wire alarm_zero_enable = int_ctrl_r[`INT_ALARM_ZERO_ENABLE_BIT];
	wire interrupt_repeat_select = int_ctrl_r[`INT_IM_BIT];

	// ******************************************************
	// register writes
	// ******************************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			sec_match_r <= `MATCH_RST;
			min_match_r <= `MATCH_RST;
			hour_match_r <= `MATCH_RST;
			date_match_r <= `MATCH_RST;
			month_match_r <= `MATCH_RST;
			wday_match_r <= `MATCH_RST;
			int_ctrl_r <= `INT_RST;
			bsw_r <= `PWR_BSW_RST;
			serial_bus_in_backup_r <= `PWR_SERIAL_BUS_IN_BACKUP_RST;
		end else if (ce && reg_wr && bus_enable) begin
			// writes only land while the bus is alive
			case (reg_addr)
			`RA_SEC_MATCH: begin
				sec_match_r <= reg_wdata;
			end
			`RA_MIN_MATCH: begin
				min_match_r <= reg_wdata;
			end
			`RA_HOUR_MATCH: begin
				hour_match_r <= reg_wdata;
			end
			`RA_DATE_MATCH: begin
				date_match_r <= reg_wdata;
			end
			`RA_MONTH_MATCH: begin
				month_match_r <= reg_wdata;
			end
			`RA_WDAY_MATCH: begin
				wday_match_r <= reg_wdata;
			end
			`RA_INT_CTRL: begin
				int_ctrl_r <= reg_wdata;
			end
			`RA_PWR_CTRL: begin
				bsw_r <= reg_wdata[`PWR_BSW_BIT];
				serial_bus_in_backup_r <= reg_wdata[`PWR_SERIAL_BUS_IN_BACKUP_BIT];
			end
			default: begin
				// unmapped: ignored
			end
			endcase
		end
	end

	// ******************************************************
	// register reads
	// ******************************************************
	// read data is registered; unmapped and dead-bus reads give zero
	always @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			if (!bus_enable) begin
				reg_rdata <= 8'h00;
			end else begin
				case (reg_addr)
				`RA_SEC_MATCH: reg_rdata <= sec_match_r;
				`RA_MIN_MATCH: reg_rdata <= min_match_r;
				`RA_HOUR_MATCH: reg_rdata <= hour_match_r;
				`RA_DATE_MATCH: reg_rdata <= date_match_r;
				`RA_MONTH_MATCH: reg_rdata <= month_match_r;
				`RA_WDAY_MATCH: reg_rdata <= wday_match_r;
				`RA_INT_CTRL: reg_rdata <= int_ctrl_r;
				`RA_STATUS: reg_rdata <= {7'h00, al0_flag_r};
				`RA_PWR_CTRL: reg_rdata <= {6'h00, serial_bus_in_backup_r, bsw_r};
				default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ******************************************************
	// backup switchover and bus gating
	// ******************************************************
	// legacy select switches on vdd<vbat, standard on the trip point
	assign in_backup = bsw_r ? ~vdd_vbat_s : ~vdd_trip_s;
	reg bus_ok;
	always @* begin
		case ({serial_bus_in_backup_r, bsw_r})
		2'b00: bus_ok = vdd_rst_s;
		2'b01: bus_ok = vdd_rst_s & (vbat_rst_s | ~in_backup);
		2'b10: bus_ok = vdd_rst_s;
		2'b11: bus_ok = vdd_rst_s & vdd_vbat_s;
		default: bus_ok = 1'b0;
		endcase
	end
	// below the reset threshold nothing talks, whatever the mode
	assign bus_enable = bus_ok & vdd_rst_s;
	// standard mode without serial_bus_in_backup shuts the pin down in backup
	assign frequency_or_interrupt_pin_active = ~in_backup | serial_bus_in_backup_r | bsw_r;

	// ******************************************************
	// once-per-second compare strobe
	// ******************************************************
	// wait one cycle after the edge so the time fields are settled
	always @(posedge mclk) begin
		if (!rst_n) begin
			tick_d_r <= 1'b0;
			tick_seen_r <= 1'b0;
		end else if (ce) begin
			tick_d_r <= tick_s;
			tick_seen_r <= tick_s & ~tick_d_r;
		end
	end

	// ******************************************************
	// field comparators
	// ******************************************************
	wire [5:0] hits;
	field_match u_fm_sec (.match_reg(sec_match_r),
		.cur_value(cur_sec), .hit(hits[0]));
	field_match u_fm_min (.match_reg(min_match_r),
		.cur_value(cur_min), .hit(hits[1]));
	field_match u_fm_hour (.match_reg(hour_match_r),
		.cur_value({1'b0, cur_hour}), .hit(hits[2]));
	field_match u_fm_date (.match_reg(date_match_r),
		.cur_value({1'b0, cur_date}), .hit(hits[3]));
	field_match u_fm_month (.match_reg(month_match_r),
		.cur_value({2'b00, cur_month}), .hit(hits[4]));
	field_match u_fm_wday (.match_reg(wday_match_r),
		.cur_value({4'h0, cur_wday}), .hit(hits[5]));
	// no field enabled means no alarm at all
	wire any_en = sec_match_r[7] | min_match_r[7] | hour_match_r[7] |
		date_match_r[7] | month_match_r[7] | wday_match_r[7];
	wire match_all = &hits & any_en;
	wire trigger = tick_seen_r & match_all & alarm_zero_enable &
		(interrupt_repeat_select | ~single_done_r);

	// ******************************************************
	// status flag and single-event latch
	// ******************************************************
	// reading status clears the flag; a trigger in that cycle wins
	wire stat_rd = ce & reg_rd & bus_enable & (reg_addr == `RA_STATUS);
	always @(posedge mclk) begin
		if (!rst_n) begin
			al0_flag_r <= 1'b0;
			single_done_r <= 1'b0;
		end else if (ce) begin
			if (trigger) begin
				al0_flag_r <= 1'b1;
			end else if (stat_rd) begin
				al0_flag_r <= 1'b0;
			end
			// rearm single mode when alarm setup is rewritten
			if (trigger && !interrupt_repeat_select) begin
				single_done_r <= 1'b1;
			end else if (reg_wr && bus_enable &&
				reg_addr <= `RA_INT_CTRL) begin
				single_done_r <= 1'b0;
			end
		end
	end
	assign alarm_zero_flag = al0_flag_r;

	// ******************************************************
	// interrupt output
	// ******************************************************
	// repeat mode gives a fixed pulse; single mode follows the flag
	always @* begin
		pulse_cnt_nxt = pulse_cnt_r;
		if (trigger && interrupt_repeat_select) begin
			pulse_cnt_nxt = `IRQ_PULSE_CYC;
		end else if (pulse_cnt_r != 7'h00) begin
			pulse_cnt_nxt = pulse_cnt_r - 7'h01;
		end
	end
	always @(posedge mclk) begin
		if (!rst_n) begin
			pulse_cnt_r <= 7'h00;
		end else if (ce) begin
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end
	// gated off when the pin is not powered in backup
	assign alarm_irq = frequency_or_interrupt_pin_active & (interrupt_repeat_select ?
		(pulse_cnt_r != 7'h00) : al0_flag_r);
endmodule

// ===== tb/rtc_alarm_gate_properties.sv
// checker for the alarm and backup-gating block
`timescale 1ns/1ps
`include "rtc_alarm_consts.vh"
module rtc_alarm_gate_properties (
	input wire mclk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire tick_1hz,
	input wire vdd_above_reset,
	input wire vdd_above_trip,
	input wire vdd_above_vbat,
	input wire vbat_above_reset,
	input wire bus_enable,
	input wire in_backup,
	input wire frequency_or_interrupt_pin_active,
	input wire alarm_zero_flag
);
// ****************
// shadow mode bits and synced supplies
// ****************
reg [1:0] mode_r; // {bus in backup, backup select}
reg [7:0] sh_r; // two sync stages, second in the low nibble
wire bk = mode_r[0] ? !sh_r[2] : !sh_r[1];
wire bus_x = (mode_r == 2'b01) ? sh_r[0] & (sh_r[3] | !bk) :
	(mode_r == 2'b11) ? sh_r[0] & sh_r[2] : sh_r[0];
// shadows mirror the block's reset, so no gap after release
always @(posedge mclk) begin
	if (!rst_n) begin
		mode_r <= 2'b01;
		sh_r <= 8'h00;
	end else begin
		sh_r <= {vbat_above_reset, vdd_above_vbat, vdd_above_trip,
			vdd_above_reset, sh_r[7:4]};
		if (reg_wr && bus_enable && reg_addr == `RA_PWR_CTRL)
			mode_r <= reg_wdata[1:0];
	end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
bus_off_low_a: assert property (
	!vdd_above_reset [*3] |-> !bus_enable) else $error("bus open");
bus_gate_a: assert property (
	bus_enable == bus_x) else $error("bus gating wrong");
backup_mode_a: assert property (
	in_backup == bk) else $error("switchover wrong");
freq_pin_a: assert property (
	frequency_or_interrupt_pin_active == (!bk || mode_r != 2'b00)) else $error("pin");
read_refused_a: assert property (
	reg_rd && (!bus_enable || reg_addr > `RA_PWR_CTRL) |=>
	reg_rdata == 8'h00) else $error("refused read gave data");
flag_on_tick_a: assert property (
	$rose(alarm_zero_flag) |-> $past(tick_1hz, 2)) else $error("flag");
status_clear_a: assert property (reg_rd && bus_enable && !tick_1hz &&
	reg_addr == `RA_STATUS |=> !alarm_zero_flag) else $error("clear");
flag_hold_a: assert property (
	alarm_zero_flag && !reg_rd |=> alarm_zero_flag) else $error("lost");
cover property ($rose(alarm_zero_flag));
cover property (reg_rd && !bus_enable);
cover property (in_backup && bus_enable);
endmodule
bind rtc_alarm_gate rtc_alarm_gate_properties chk_inst (.mclk, .rst_n,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .tick_1hz,
	.vdd_above_reset, .vdd_above_trip, .vdd_above_vbat, .vbat_above_reset,
	.bus_enable, .in_backup, .frequency_or_interrupt_pin_active, .alarm_zero_flag);

// ===== tb/reg_host.sv
// register host model for the block's register port
`timescale 1ns/1ps
module reg_host (
	input wire mclk,
	output reg reg_wr,
	output reg reg_rd,
	output reg [3:0] reg_addr,
	output reg [7:0] reg_wdata,
	input wire [7:0] reg_rdata
);
// idle at time zero
initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
// one request held for one taken edge; released lines show inverse
task xfer(input w, input [3:0] a, input [7:0] d, output [7:0] q);
	begin
		@(posedge mclk);
		#1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(posedge mclk);
		#1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
		q = reg_rdata;
	end
endtask
endmodule

// ===== tb/tb_rtc_alarm_gate.sv
// self-checking bench for the alarm and backup-gating block
`timescale 1ns/1ps
module tb_rtc_alarm_gate;
reg mclk, rst_n, tick_1hz;
reg [6:0] cur_sec, cur_min;
reg [5:0] cur_hour, cur_date;
reg [4:0] cur_month;
reg [2:0] cur_wday;
reg [3:0] sup; // {vbat>reset, vdd>vbat, vdd>trip, vdd>reset}
reg [7:0] rv;
reg [47:0] al; // six match bytes, seconds lowest
wire reg_wr, reg_rd, bus_enable, in_backup, frequency_or_interrupt_pin_active;
wire alarm_irq, alarm_zero_flag;
wire [3:0] reg_addr;
wire [7:0] reg_wdata, reg_rdata;
integer mismatches, checks_done, i, j, armed, mflag, hit, bk;
integer mreg [0:8]; // reference register file
reg_host reg_host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
rtc_alarm_gate rtc_alarm_gate_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tick_1hz(tick_1hz),
	.cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
	.cur_date(cur_date), .cur_month(cur_month), .cur_wday(cur_wday),
	.vdd_above_reset(sup[0]), .vdd_above_trip(sup[1]),
	.vdd_above_vbat(sup[2]), .vbat_above_reset(sup[3]),
	.bus_enable(bus_enable), .in_backup(in_backup),
	.frequency_or_interrupt_pin_active(frequency_or_interrupt_pin_active), .alarm_irq(alarm_irq),
	.alarm_zero_flag(alarm_zero_flag));
task cmp8(input [7:0] got, input integer exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp[7:0]) begin
			mismatches = mismatches + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp[7:0]);
		end
	end
endtask
task mwr(input [3:0] a, input [7:0] d);
	begin
		reg_host_inst.xfer(1'b1, a, d, rv);
		mreg[a] = d;
		armed = (a <= 4'h6) ? 1 : armed;
	end
endtask
// status read empties the flag
task mrd(input [3:0] a);
	begin
		reg_host_inst.xfer(1'b0, a, 8'h00, rv);
		cmp8(rv, a == 4'h7 ? mflag : a <= 4'h8 ? mreg[a] : 0);
		mflag = (a == 4'h7) ? 0 : mflag;
	end
endtask
// a field takes part only with its enable bit
function integer fm(input integer r, input integer v);
	fm = !r[7] || r[6:0] == v;
endfunction
function [6:0] bcd(input integer v);
	bcd = ((v / 10) << 4) | (v % 10);
endfunction
// one second advance: tick is async, phase unrelated to mclk
task tock;
	begin
		hit = mreg[6][5] && (armed || mreg[6][7]) && ((mreg[0] | mreg[1] |
			mreg[2] | mreg[3] | mreg[4] | mreg[5]) & 128) &&
			fm(mreg[0], cur_sec) && fm(mreg[1], cur_min) &&
			fm(mreg[2], cur_hour) && fm(mreg[3], cur_date) &&
			fm(mreg[4], cur_month) && fm(mreg[5], cur_wday);
		mflag = hit ? 1 : mflag;
		armed = hit ? mreg[6][7] : armed;
		#62.5 tick_1hz = 1'b1;
		#62.5 tick_1hz = 1'b0;
		repeat (2) @(posedge mclk);
		#1 cmp8(alarm_zero_flag, mflag);
		cmp8(alarm_irq, mreg[6][7] ? hit : mflag);
		if (hit && mreg[6][7]) begin
			repeat (100) @(posedge mclk);
			#1 cmp8(alarm_irq, 0);
		end
	end
endtask
task end_of_test;
	begin
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
endtask
initial begin
	mclk = 1'b0;
	forever #5 mclk = ~mclk;
end
// watchdog: the tests need well under 100 us
initial begin
	#500000;
	mismatches = mismatches + 1;
	end_of_test;
end
initial begin
	{mismatches, checks_done, mflag, armed} = 0;
	{rst_n, tick_1hz, sup} = 6'h0f;
	{cur_sec, cur_min, cur_hour, cur_date, cur_month, cur_wday} = 34'h0;
	for (i = 0; i < 9; i = i + 1)
		mreg[i] = (i == 8) ? 1 : 0;
	rv = $urandom(99);
	repeat (5) @(posedge mclk);
	#1 rst_n = 1'b1;
	repeat (4) @(posedge mclk);
	for (i = 0; i < 10; i = i + 1)
		mrd(i[3:0]);
	for (i = 0; i < 6; i = i + 1)
		mwr(i[3:0], $urandom % 256);
	for (i = 0; i < 6; i = i + 1)
		mrd(i[3:0]);
	for (i = 0; i < 4; i = i + 1) begin
		mwr(4'h8, i[7:0]);
		for (j = 0; j < 16; j = j + 1) begin
			sup = j[3:0];
			repeat (4) @(posedge mclk);
			#1 bk = i[0] ? !sup[2] : !sup[1];
			cmp8(in_backup, bk);
			cmp8(frequency_or_interrupt_pin_active, !bk || i > 0);
			cmp8(bus_enable, i == 1 ? sup[0] && (sup[3] || !bk) :
				i == 3 ? sup[0] && sup[2] : sup[0]);
			if (j == 0)
				reg_host_inst.xfer(1'b1, 4'h6, 8'ha0, rv);
		end
		sup = 4'hf;
		repeat (4) @(posedge mclk);
		#1 mrd(4'h6);
	end
	al = 48'h008181_91b000;
	for (i = 0; i < 6; i = i + 1)
		mwr(i[3:0], al[8 * i +: 8]);
	{cur_sec, cur_min, cur_hour, cur_date, cur_month, cur_wday} =
		{7'h00, 7'h30, 6'h11, 6'h01, 5'h01, 3'h2};
	tock;
	mwr(4'h6, 8'h20);
	cur_hour = 6'h12;
	tock;
	cur_hour = 6'h11;
	tock;
	mrd(4'h7);
	tock;
	al = 48'hb0;
	for (i = 0; i < 6; i = i + 1)
		mwr(i[3:0], al[8 * i +: 8]);
	mwr(4'h6, 8'ha0);
	cur_sec = 7'h30;
	tock;
	tock;
	for (j = 0; j < 6; j = j + 1) begin
		i = $urandom % 60;
		mwr(4'h0, {1'b1, bcd(i)});
		mwr(4'h6, 8'h20 | ($urandom % 2) << 7);
		cur_sec = bcd(($urandom % 2) ? i : (i + 1) % 60);
		tock;
	end
	end_of_test;
end
endmodule
